/* File: switch_policy_defines.svh */
// constants for the switch global policy control block
`ifndef SWITCH_POLICY_DEFINES_SVH
`define SWITCH_POLICY_DEFINES_SVH

// ********************
// register offsets
// ********************
`define AGING_BACKOFF_OFFSET     8'h03
`define FORWARDING_POLICY_OFFSET 8'h04

// ********************
// aging/back-off control field positions
// ********************
`define AGE_EN_BIT       2
`define FAST_AGE_BIT     1
`define AGGR_BACKOFF_BIT 0

// ********************
// forwarding policy field positions
// ********************
`define VLAN_DISCARD_BIT   7
`define MCAST_EXCL_BIT     6
`define BP_MODE_BIT        5
`define FAIR_MODE_BIT      4
`define NO_COLL_DROP_BIT   3
`define HUGE_FRAME_BIT     2
`define LEGAL_MAX_DIS_BIT  1
`define PRIO_RESERVE_BIT   0

// ********************
// reset values (strap fields are loaded after release)
// ********************
`define AGING_BACKOFF_RESET     8'h00
`define FORWARDING_POLICY_RESET 8'hF0

// ********************
// frame limits and collision limit
// ********************
`define HUGE_FRAME_LEN      11'h77C
`define EXT_FRAME_LEN       11'h600
`define TAGGED_FRAME_LEN    11'h5F2
`define UNTAGGED_FRAME_LEN  11'h5EE
`define EXCESS_COLL_COUNT   5'h10

// ********************
// timing
// ********************
`define CLK_PERIOD_NS   50
`define CLK_RATE_HZ     20000000
`define FAST_AGE_NS     800000
`define NORMAL_AGE_S    300
`define FAST_AGE_CYC    (`FAST_AGE_NS / `CLK_PERIOD_NS)
`define NORMAL_AGE_CYC  (64'd`NORMAL_AGE_S * 64'd`CLK_RATE_HZ)
`define STRAP_FILL_CYC  3

`endif

/* File: switch_policy_pkg.sv */
// types for the switch global policy control block
package switch_policy_pkg;

   typedef enum logic [0:0]
   {
      strap_wait,
      strap_done
   } strap_state_t;

   typedef logic [10:0] frame_len_t;

endpackage : switch_policy_pkg

/* File: strap_sync.sv */
// three-stage synchroniser for strap pins with a fill delay
`timescale 1ns/1ps
`include "switch_policy_defines.svh"

module strap_sync #(
   parameter int WIDTH = 3
) (
   input  wire logic             i_clk,
   input  wire logic             i_reset,
   input  wire logic [WIDTH-1:0] i_pin,
   output logic      [WIDTH-1:0] o_level,
   output logic                  o_stable
);

   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [1:0]       fill_q;
   logic [1:0]       fill_d;

   always_comb
   begin
      fill_d = fill_q;
      if (fill_q != 2'(`STRAP_FILL_CYC))
      begin
         fill_d = fill_q + 2'h1;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         s1_q   <= '0;
         s2_q   <= '0;
         s3_q   <= '0;
         fill_q <= 2'h0;
      end
      else
      begin
         s1_q   <= i_pin;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         fill_q <= fill_d;
      end
   end

   // a level counts only once the pipe is full and two stages agree
   assign o_level  = s3_q;
   assign o_stable = (fill_q == 2'(`STRAP_FILL_CYC)) && (s2_q == s3_q);

endmodule : strap_sync

/* File: switch_global_policy_control.sv */
// global policy control registers and per-frame policy decisions of the switch
`timescale 1ns/1ps
`include "switch_policy_defines.svh"

module switch_global_policy_control
   import switch_policy_pkg::*;
#(
   parameter logic [35:0] FAST_AGE_CYCLES   = 36'(`FAST_AGE_CYC),
   parameter logic [35:0] NORMAL_AGE_CYCLES = 36'(`NORMAL_AGE_CYC)
) (
   input  wire logic       i_clk,
   input  wire logic       i_reset,
   // strap pins
   input  wire logic       i_aging_strap_pin,
   input  wire logic       i_backoff_strap_pin,
   input  wire logic       i_collision_drop_strap_pin,
   input  wire logic       i_size_check_strap_pin,
   // register port
   input  wire logic [7:0] i_reg_addr,
   input  wire logic [7:0] i_reg_wdata,
   input  wire logic       i_reg_wr,
   input  wire logic       i_reg_rd,
   output logic      [7:0] o_reg_rdata,
   output logic            o_reg_rvalid,
   // frame classification request
   input  wire logic       i_frame_valid,
   input  wire frame_len_t i_frame_len,
   input  wire logic       i_frame_tagged,
   input  wire logic       i_frame_unicast_known,
   input  wire logic       i_frame_crosses_vlan,
   input  wire logic       i_frame_da_bcast,
   input  wire logic       i_frame_da_group,
   output logic            o_verdict_valid,
   output logic            o_size_drop,
   output logic            o_vlan_drop,
   output logic            o_storm_count,
   // collision and contention events
   input  wire logic       i_coll_valid,
   input  wire logic [4:0] i_coll_count,
   output logic            o_coll_drop,
   output logic            o_coll_retry,
   input  wire logic       i_contend,
   output logic            o_drop_nonfc,
   output logic            o_hold_fc,
   // policy levels and aging
   output logic            o_age_tick,
   output logic            o_aggressive_backoff,
   output logic            o_bp_carrier_sense,
   output logic            o_strap_loaded
);

   // ********************
   // strap capture
   // ********************
   logic [3:0]   strap_level;
   logic         strap_stable;
   strap_state_t strap_q;
   strap_state_t strap_d;

   strap_sync #(
      .WIDTH (4)
   ) u_strap_sync (
      .i_clk    (i_clk),
      .i_reset  (i_reset),
      .i_pin    ({i_size_check_strap_pin, i_collision_drop_strap_pin,
                  i_backoff_strap_pin, i_aging_strap_pin}),
      .o_level  (strap_level),
      .o_stable (strap_stable)
   );

   logic strap_load;

   always_comb
   begin
      strap_d    = strap_q;
      strap_load = 1'b0;
      case (strap_q)
         strap_wait:
         begin
            if (strap_stable)
            begin
               strap_load = 1'b1;
               strap_d    = strap_done;
            end
         end
         strap_done: strap_d = strap_done;
         default:    strap_d = strap_wait;
      endcase
   end

   // ********************
   // registers
   // ********************
   logic [7:0] ctl1_q;
   logic [7:0] ctl1_d;
   logic [7:0] ctl2_q;
   logic [7:0] ctl2_d;
   logic [7:0] rdata_d;

   always_comb
   begin
      ctl1_d = ctl1_q;
      ctl2_d = ctl2_q;
      if (i_reg_wr && i_reg_addr == `AGING_BACKOFF_OFFSET)
      begin
         ctl1_d = i_reg_wdata;
      end
      if (i_reg_wr && i_reg_addr == `FORWARDING_POLICY_OFFSET)
      begin
         ctl2_d = i_reg_wdata;
      end
      // strap values win over a write that lands in the load cycle
      if (strap_load)
      begin
         ctl1_d[`AGE_EN_BIT]        = strap_level[0];
         ctl1_d[`AGGR_BACKOFF_BIT]  = strap_level[1];
         ctl2_d[`NO_COLL_DROP_BIT]  = strap_level[2];
         ctl2_d[`LEGAL_MAX_DIS_BIT] = strap_level[3];
      end
      case (i_reg_addr)
         `AGING_BACKOFF_OFFSET:     rdata_d = ctl1_q;
         `FORWARDING_POLICY_OFFSET: rdata_d = ctl2_q;
         default:                   rdata_d = 8'h00;
      endcase
   end

   // ********************
   // aging timer
   // ********************
   logic [35:0] age_cnt_q;
   logic [35:0] age_cnt_d;
   logic [35:0] age_period;
   logic        age_tick_d;

   always_comb
   begin
      age_period = ctl1_q[`FAST_AGE_BIT] ? FAST_AGE_CYCLES : NORMAL_AGE_CYCLES;
      age_cnt_d  = 36'h0;
      age_tick_d = 1'b0;
      if (ctl1_q[`AGE_EN_BIT])
      begin
         // >= catches a switch from normal to fast with a large count
         if (age_cnt_q >= age_period - 36'h1)
         begin
            age_tick_d = 1'b1;
         end
         else
         begin
            age_cnt_d = age_cnt_q + 36'h1;
         end
      end
   end

   // ********************
   // frame and event decisions
   // ********************
   frame_len_t max_len;
   logic       size_drop_d;
   logic       vlan_drop_d;
   logic       storm_d;
   logic       coll_drop_d;
   logic       coll_retry_d;
   logic       drop_nonfc_d;
   logic       hold_fc_d;

   always_comb
   begin
      if (ctl2_q[`HUGE_FRAME_BIT])
      begin
         max_len = `HUGE_FRAME_LEN;
      end
      else if (ctl2_q[`LEGAL_MAX_DIS_BIT])
      begin
         max_len = `EXT_FRAME_LEN;
      end
      else
      begin
         max_len = i_frame_tagged ? `TAGGED_FRAME_LEN : `UNTAGGED_FRAME_LEN;
      end
      size_drop_d  = i_frame_valid && (i_frame_len > max_len);
      vlan_drop_d  = i_frame_valid && i_frame_crosses_vlan
                     && (ctl2_q[`VLAN_DISCARD_BIT] || !i_frame_unicast_known);
      storm_d      = i_frame_valid && (i_frame_da_bcast
                     || (!ctl2_q[`MCAST_EXCL_BIT] && i_frame_da_group));
      coll_drop_d  = i_coll_valid && (i_coll_count >= `EXCESS_COLL_COUNT)
                     && !ctl2_q[`NO_COLL_DROP_BIT];
      coll_retry_d = i_coll_valid && !coll_drop_d;
      drop_nonfc_d = i_contend && ctl2_q[`FAIR_MODE_BIT];
      hold_fc_d    = i_contend && !ctl2_q[`FAIR_MODE_BIT];
   end

   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         strap_q              <= strap_wait;
         ctl1_q               <= `AGING_BACKOFF_RESET;
         ctl2_q               <= `FORWARDING_POLICY_RESET;
         o_reg_rdata          <= 8'h00;
         o_reg_rvalid         <= 1'b0;
         age_cnt_q            <= 36'h0;
         o_age_tick           <= 1'b0;
         o_verdict_valid      <= 1'b0;
         o_size_drop          <= 1'b0;
         o_vlan_drop          <= 1'b0;
         o_storm_count        <= 1'b0;
         o_coll_drop          <= 1'b0;
         o_coll_retry         <= 1'b0;
         o_drop_nonfc         <= 1'b0;
         o_hold_fc            <= 1'b0;
         o_aggressive_backoff <= 1'b0;
         o_bp_carrier_sense   <= 1'b1;
         o_strap_loaded       <= 1'b0;
      end
      else
      begin
         strap_q              <= strap_d;
         ctl1_q               <= ctl1_d;
         ctl2_q               <= ctl2_d;
         o_reg_rdata          <= i_reg_rd ? rdata_d : 8'h00;
         o_reg_rvalid         <= i_reg_rd;
         age_cnt_q            <= age_cnt_d;
         o_age_tick           <= age_tick_d;
         o_verdict_valid      <= i_frame_valid;
         o_size_drop          <= size_drop_d;
         o_vlan_drop          <= vlan_drop_d;
         o_storm_count        <= storm_d;
         o_coll_drop          <= coll_drop_d;
         o_coll_retry         <= coll_retry_d;
         o_drop_nonfc         <= drop_nonfc_d;
         o_hold_fc            <= hold_fc_d;
         o_aggressive_backoff <= ctl1_d[`AGGR_BACKOFF_BIT];
         o_bp_carrier_sense   <= ctl2_d[`BP_MODE_BIT];
         o_strap_loaded       <= (strap_d == strap_done);
      end
   end

   // ********************
   // assertions
   // ********************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   aging_off_a: assert property (!$past(ctl1_q[`AGE_EN_BIT]) |-> !o_age_tick)
      else $error("age tick while aging disabled");
   fast_period_a: assert property ($past(ctl1_q[`FAST_AGE_BIT]) && ctl1_q[`FAST_AGE_BIT]
      |-> age_cnt_q < FAST_AGE_CYCLES)
      else $error("fast aging count exceeds period");
   backoff_level_a: assert property (##1
      o_aggressive_backoff == ctl1_q[`AGGR_BACKOFF_BIT])
      else $error("back-off output does not follow field");
   vlan_drop_a: assert property (i_frame_valid && i_frame_crosses_vlan
      && !i_frame_unicast_known |=> o_verdict_valid && o_vlan_drop)
      else $error("non-unicast frame crossed vlan");
   vlan_strict_a: assert property (i_frame_valid && i_frame_crosses_vlan
      && ctl2_q[`VLAN_DISCARD_BIT] |=> o_vlan_drop)
      else $error("frame crossed vlan with discard set");
   storm_mcast_a: assert property (i_frame_valid && i_frame_da_group && !i_frame_da_bcast
      |=> o_storm_count == !$past(ctl2_q[`MCAST_EXCL_BIT]))
      else $error("storm counting ignores exclusion field");
   bp_mode_a: assert property (##1 o_bp_carrier_sense == ctl2_q[`BP_MODE_BIT])
      else $error("back-pressure output does not follow field");
   fair_mode_a: assert property (i_contend
      |=> (o_drop_nonfc == $past(ctl2_q[`FAIR_MODE_BIT])) && (o_hold_fc != o_drop_nonfc))
      else $error("contention action wrong for fair mode");
   coll_limit_a: assert property (i_coll_valid && i_coll_count == 5'h10
      |=> (o_coll_drop != $past(ctl2_q[`NO_COLL_DROP_BIT])) && (o_coll_drop != o_coll_retry))
      else $error("excessive collision handling wrong");
   strap_load_a: assert property (strap_load
      |=> ctl2_q[`NO_COLL_DROP_BIT] == $past(strap_level[2])
      && ctl1_q[`AGE_EN_BIT] == $past(strap_level[0]))
      else $error("strap value not loaded");
   huge_len_a: assert property (i_frame_valid && ctl2_q[`HUGE_FRAME_BIT]
      |=> o_size_drop == ($past(i_frame_len) > `HUGE_FRAME_LEN))
      else $error("huge frame limit wrong");
   std_len_a: assert property (i_frame_valid && !ctl2_q[`HUGE_FRAME_BIT]
      && !ctl2_q[`LEGAL_MAX_DIS_BIT] && !i_frame_tagged
      |=> o_size_drop == ($past(i_frame_len) > `UNTAGGED_FRAME_LEN))
      else $error("untagged frame limit wrong");

endmodule : switch_global_policy_control

/* File: testbench.sv */
// self-checking testbench for the switch global policy control block
`timescale 1ns/1ps
`include "switch_policy_defines.svh"

module testbench
   import switch_policy_pkg::*;
;
   // ***********************
   // stimulus and observed signals
   // ***********************
   logic       i_clk, i_reset, s_age, s_bo, s_coll, s_size;
   logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
   logic       i_reg_wr, i_reg_rd, o_reg_rvalid;
   logic       i_frame_valid, f_tag, f_uk, f_cross, f_bc, f_grp;
   frame_len_t i_frame_len;
   logic       o_verdict_valid, o_size_drop, o_vlan_drop, o_storm_count;
   logic       i_coll_valid, o_coll_drop, o_coll_retry, i_contend, o_drop_nonfc, o_hold_fc;
   logic [4:0] i_coll_count;
   logic       o_age_tick, o_aggressive_backoff, o_bp_carrier_sense, o_strap_loaded;
   logic [7:0] r3, r4;
   int         num_errors, n_compared, seed, cycles, k, n;
   frame_len_t lens [8] = '{11'h5EE, 11'h5EF, 11'h5F2, 11'h5F3, 11'h600, 11'h601, 11'h77C, 11'h77D};

   // short periods keep the aging checks inside the run budget
   switch_global_policy_control #(.FAST_AGE_CYCLES(36'h8), .NORMAL_AGE_CYCLES(36'h14))
   i_switch_global_policy_control (
      .i_clk(i_clk), .i_reset(i_reset), .i_aging_strap_pin(s_age),
      .i_backoff_strap_pin(s_bo), .i_collision_drop_strap_pin(s_coll),
      .i_size_check_strap_pin(s_size), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
      .o_reg_rvalid(o_reg_rvalid), .i_frame_valid(i_frame_valid), .i_frame_len(i_frame_len),
      .i_frame_tagged(f_tag), .i_frame_unicast_known(f_uk), .i_frame_crosses_vlan(f_cross),
      .i_frame_da_bcast(f_bc), .i_frame_da_group(f_grp), .o_verdict_valid(o_verdict_valid),
      .o_size_drop(o_size_drop), .o_vlan_drop(o_vlan_drop), .o_storm_count(o_storm_count),
      .i_coll_valid(i_coll_valid), .i_coll_count(i_coll_count), .o_coll_drop(o_coll_drop),
      .o_coll_retry(o_coll_retry), .i_contend(i_contend), .o_drop_nonfc(o_drop_nonfc),
      .o_hold_fc(o_hold_fc), .o_age_tick(o_age_tick),
      .o_aggressive_backoff(o_aggressive_backoff), .o_bp_carrier_sense(o_bp_carrier_sense),
      .o_strap_loaded(o_strap_loaded)
   );

   always #25 i_clk = ~i_clk;

   // a hang counts as a mismatch and still reaches the verdict
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         num_errors++;
         report_and_stop();
      end
   end

   // ***********************
   // shared tasks
   // ***********************
   task check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task report_and_stop();
      $display("errors=%0d compares=%0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop

   task reg_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      i_reg_addr = a;
      i_reg_wdata = d;
      i_reg_wr = 1'b1;
      @(negedge i_clk);
      i_reg_wr = 1'b0;
      if (a == `AGING_BACKOFF_OFFSET)
         r3 = d;
      if (a == `FORWARDING_POLICY_OFFSET)
         r4 = d;
   endtask : reg_write

   task reg_read(input logic [7:0] a, input logic [7:0] exp);
      @(negedge i_clk);
      i_reg_addr = a;
      i_reg_rd = 1'b1;
      @(negedge i_clk);
      i_reg_rd = 1'b0;
      check(o_reg_rdata, exp);
      check({7'h00, o_reg_rvalid}, 8'h01);
   endtask : reg_read

   function automatic frame_len_t frame_limit(input logic [7:0] r, input logic tg);
      if (r[`HUGE_FRAME_BIT])
         return `HUGE_FRAME_LEN;
      if (r[`LEGAL_MAX_DIS_BIT])
         return `EXT_FRAME_LEN;
      return tg ? `TAGGED_FRAME_LEN : `UNTAGGED_FRAME_LEN;
   endfunction : frame_limit

   task send_frame(input frame_len_t len, input logic [4:0] f);
      logic e_size, e_vlan, e_storm;
      e_size = len > frame_limit(r4, f[0]);
      e_vlan = f[2] & (r4[`VLAN_DISCARD_BIT] | ~f[1]);
      e_storm = f[3] | (~r4[`MCAST_EXCL_BIT] & f[4]);
      @(negedge i_clk);
      i_frame_valid = 1'b1;
      i_frame_len = len;
      {f_grp, f_bc, f_cross, f_uk, f_tag} = f;
      @(negedge i_clk);
      i_frame_valid = 1'b0;
      check({7'h00, o_verdict_valid}, 8'h01);
      check({7'h00, o_size_drop}, {7'h00, e_size});
      check({7'h00, o_vlan_drop}, {7'h00, e_vlan});
      check({7'h00, o_storm_count}, {7'h00, e_storm});
   endtask : send_frame

   task send_events(input logic [4:0] cnt);
      logic e_drop;
      e_drop = (cnt >= `EXCESS_COLL_COUNT) & ~r4[`NO_COLL_DROP_BIT];
      @(negedge i_clk);
      i_coll_valid = 1'b1;
      i_coll_count = cnt;
      i_contend = 1'b1;
      @(negedge i_clk);
      i_coll_valid = 1'b0;
      i_contend = 1'b0;
      check({6'h00, o_coll_drop, o_coll_retry}, {6'h00, e_drop, ~e_drop});
      check({6'h00, o_drop_nonfc, o_hold_fc}, {6'h00, r4[4], ~r4[4]});
   endtask : send_events

   task wait_tick();
      n = 0;
      do
      begin
         @(negedge i_clk);
         n++;
      end
      while (o_age_tick !== 1'b1 && n < 100);
   endtask : wait_tick

   // ***********************
   // main sequence
   // ***********************
   initial
   begin
      seed = 67;
      {i_clk, i_reg_wr, i_reg_rd, i_frame_valid, i_coll_valid, i_contend} = 6'h00;
      {f_tag, f_uk, f_cross, f_bc, f_grp} = 5'h00;
      {i_reg_addr, i_reg_wdata, i_frame_len, i_coll_count} = 32'h00000000;
      {s_age, s_bo, s_coll, s_size} = 4'($random(seed));
      i_reset = 1'b1;
      repeat (3) @(posedge i_clk);
      check({7'h00, o_bp_carrier_sense}, 8'h01);
      @(negedge i_clk);
      i_reset = 1'b0;
      k = 0;
      while (o_strap_loaded !== 1'b1 && k < 20)
      begin
         @(negedge i_clk);
         k++;
      end
      check({7'h00, o_strap_loaded}, 8'h01);
      r3 = {5'h00, s_age, 1'b0, s_bo};
      r4 = 8'hF0 | {4'h0, s_coll, 1'b0, s_size, 1'b0};
      reg_read(`AGING_BACKOFF_OFFSET, r3);
      reg_read(`FORWARDING_POLICY_OFFSET, r4);
      check({7'h00, o_aggressive_backoff}, {7'h00, s_bo});
      send_events(5'h10);
      reg_write(8'h05, 8'h5A);
      reg_read(8'h05, 8'h00);
      reg_read(`FORWARDING_POLICY_OFFSET, r4);
      for (k = 0; k < 40; k++)
      begin
         reg_write(`FORWARDING_POLICY_OFFSET, 8'($random(seed)));
         reg_write(`AGING_BACKOFF_OFFSET, 8'($random(seed)));
         reg_read(`FORWARDING_POLICY_OFFSET, r4);
         check({7'h00, o_aggressive_backoff}, {7'h00, r3[0]});
         check({7'h00, o_bp_carrier_sense}, {7'h00, r4[5]});
         repeat (4)
            send_frame(($random(seed) & 3) == 0 ? 11'($random(seed)) : lens[$random(seed) & 7],
                       5'($random(seed)));
         send_events(k % 3 == 0 ? 5'h0F : (k % 3 == 1 ? 5'h10 : 5'($random(seed))));
      end
      reg_write(`AGING_BACKOFF_OFFSET, 8'h04);
      wait_tick();
      wait_tick();
      check(8'(n), 8'h14);
      reg_write(`AGING_BACKOFF_OFFSET, 8'h06);
      wait_tick();
      wait_tick();
      check(8'(n), 8'h08);
      reg_write(`AGING_BACKOFF_OFFSET, 8'h02);
      n = 0;
      repeat (40)
      begin
         @(negedge i_clk);
         n += (o_age_tick !== 1'b0);
      end
      check(8'(n), 8'h00);
      // second reset with inverted straps covers the other strap levels
      @(negedge i_clk);
      {s_age, s_bo, s_coll, s_size} = ~{s_age, s_bo, s_coll, s_size};
      i_reset = 1'b1;
      repeat (3) @(negedge i_clk);
      i_reset = 1'b0;
      repeat (6) @(negedge i_clk);
      check({7'h00, o_strap_loaded}, 8'h01);
      r3 = {5'h00, s_age, 1'b0, s_bo};
      r4 = 8'hF0 | {4'h0, s_coll, 1'b0, s_size, 1'b0};
      reg_read(`AGING_BACKOFF_OFFSET, r3);
      reg_read(`FORWARDING_POLICY_OFFSET, r4);
      check({7'h00, o_aggressive_backoff}, {7'h00, s_bo});
      send_events(5'h10);
      report_and_stop();
   end
endmodule : testbench
